//--- rtl/scoc_combiner.sv
// Purpose: Keystream generator plus XOR or authenticated combiner.
// Assumes: One block per handshake; host keeps blocks whole.
// Notes:   Authenticated decrypt buffers up to MAX_BLKS plaintext blocks.
`timescale 1ns/1ps
module scoc_combiner #(
  parameter int MAX_BLKS = 64,
  parameter int R_FB     = 2
) (
  input  wire logic sys_clk_i,
  input  wire logic srst_i,
  scoc_link_if.dev  link
);
  localparam int NB_W = $clog2(MAX_BLKS) + 1;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FIND = 3'b001,
    ST_INV  = 3'b010,
    ST_RUN  = 3'b011,
    ST_TAIL = 3'b100,
    ST_EMIT = 3'b101,
    ST_VERD = 3'b110,
    ST_REL  = 3'b111
  } scoc_state_e;

  scoc_state_e         state_reg;
  logic                dir_reg;
  scoc_pkg::scoc_out_e omode_reg;
  scoc_pkg::scoc_gen_e gmode_reg;
  scoc_pkg::scoc_blk_t key_reg;
  scoc_pkg::scoc_blk_t red_reg;
  scoc_pkg::scoc_blk_t gs_reg;
  scoc_pkg::scoc_blk_t hist_reg [R_FB];
  scoc_pkg::scoc_blk_t zt_reg;
  scoc_pkg::scoc_blk_t zinv_reg;
  scoc_pkg::scoc_blk_t sq_reg;
  scoc_pkg::scoc_blk_t wprev_reg;
  scoc_pkg::scoc_blk_t za_reg;
  scoc_pkg::scoc_blk_t zb_reg;
  scoc_pkg::scoc_blk_t pm1_reg;
  scoc_pkg::scoc_blk_t pm2_reg;
  scoc_pkg::scoc_blk_t mem [MAX_BLKS];
  logic [scoc_pkg::CNT_W-1:0] cnt_reg;
  logic [NB_W-1:0]     nblk_reg;
  logic [NB_W-1:0]     rd_reg;
  logic                ovf_reg;
  logic                out_valid_reg;
  scoc_pkg::scoc_blk_t out_data_reg;
  logic                out_last_reg;
  logic                done_reg;
  logic                accept_reg;

  // Keystream path
  scoc_pkg::scoc_blk_t z_sync;
  scoc_pkg::scoc_blk_t z_ss;
  scoc_pkg::scoc_blk_t z_cur;
  scoc_pkg::scoc_blk_t gs_next;
  logic                is_auth;
  logic                is_dec_auth;
  logic                out_free;
  logic                in_fire;
  logic                start_fire;
  logic                adv;
  logic                emit;
  scoc_pkg::scoc_blk_t xor_res;
  scoc_pkg::scoc_blk_t w_enc;
  scoc_pkg::scoc_blk_t c_enc;
  scoc_pkg::scoc_blk_t x_dec;
  scoc_pkg::scoc_blk_t w_dec;
  scoc_pkg::scoc_blk_t p_dec;
  scoc_pkg::scoc_blk_t tail_w;
  scoc_pkg::scoc_blk_t c_tail;
  scoc_pkg::scoc_blk_t sq_next;
  scoc_pkg::scoc_blk_t ct_fb;
  scoc_pkg::scoc_blk_t out_next;
  logic                verdict_ok;
  logic [NB_W-1:0]     rel_last;

  assign is_auth     = omode_reg == scoc_pkg::SCOC_OUT_AUTH;
  assign is_dec_auth = is_auth && dir_reg;
  assign out_free    = !out_valid_reg || link.out_ready;
  assign start_fire  = link.start_valid && link.start_ready;
  assign in_fire     = link.in_valid && link.in_ready;

  // Strm(S,K), then Next(S,K)
  assign z_sync  = scoc_pkg::scoc_trunc(gs_reg ^ key_reg,
                                        scoc_pkg::BLK_W);
  assign gs_next = scoc_pkg::scoc_shift(gs_reg,
                     scoc_pkg::scoc_gf_mul(gs_reg, key_reg) ^ key_reg,
                     scoc_pkg::GEN_FEED);
  // Stateless: only IV and ciphertext history matter; key cancels in gs_reg ^ key_reg
  assign z_ss  = scoc_pkg::scoc_gf_mul(gs_reg ^ key_reg, hist_reg[0])
               ^ hist_reg[R_FB-1];
  assign z_cur = (gmode_reg == scoc_pkg::SCOC_GEN_SSYNC && !is_auth) ?
                 z_ss : z_sync;

  assign xor_res = link.in_data ^ z_cur;
  assign w_enc   = link.in_data ^ z_cur;
  assign c_enc   = scoc_pkg::scoc_gf_mul(zt_reg, w_enc) ^ wprev_reg;
  assign x_dec   = link.in_data ^ wprev_reg;
  assign w_dec   = scoc_pkg::scoc_gf_mul(zinv_reg, x_dec);
  assign p_dec   = w_dec ^ z_cur;
  // Tail blocks: Z[t+u+3] then redundancy
  assign tail_w  = (cnt_reg == scoc_pkg::CNT_ZERO) ?
                   (z_cur ^ za_reg) : (red_reg ^ zb_reg);
  assign c_tail  = scoc_pkg::scoc_gf_mul(zt_reg, tail_w) ^ wprev_reg;
  assign sq_next = scoc_pkg::scoc_gf_mul(sq_reg, sq_reg);
  assign ct_fb   = dir_reg ? link.in_data : xor_res;

  assign verdict_ok = !ovf_reg && (nblk_reg >= NB_W'(2))
                   && (pm2_reg == z_cur) && (pm1_reg == red_reg);
  assign rel_last   = nblk_reg - NB_W'(3);

  assign link.start_ready = state_reg == ST_IDLE;
  assign link.in_ready    = (state_reg == ST_RUN)
                         && (is_dec_auth || out_free);

  assign emit = (state_reg == ST_RUN && in_fire && !is_dec_auth)
             || (state_reg == ST_EMIT && out_free)
             || (state_reg == ST_REL && out_free);
  assign out_next = (state_reg == ST_REL)  ? mem[rd_reg[NB_W-2:0]] :
                    (state_reg == ST_EMIT) ? c_tail :
                    is_auth ? c_enc : xor_res;
  // One keystream block per search cycle, consumed data block and tail step (two tail captures, first tail emit)
  assign adv = (state_reg == ST_FIND) || (state_reg == ST_TAIL)
            || (state_reg == ST_RUN && in_fire)
            || (state_reg == ST_EMIT && out_free
                && cnt_reg == scoc_pkg::CNT_ZERO);

  assign link.out_valid = out_valid_reg;
  assign link.out_data  = out_data_reg;
  assign link.out_last  = out_last_reg;
  assign link.done      = done_reg;
  assign link.accept    = accept_reg;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      gs_reg <= scoc_pkg::BLK_ZERO;
    end else if (start_fire) begin
      gs_reg <= link.start_iv ^ link.start_key;
    end else if (adv && !(gmode_reg == scoc_pkg::SCOC_GEN_SSYNC
                          && !is_auth)) begin
      gs_reg <= gs_next;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    for (int i = 0; i < R_FB; i++) begin
      if (srst_i) begin
        hist_reg[i] <= scoc_pkg::BLK_ZERO;
      end else if (start_fire) begin
        // Dummy ciphertext seeds derived from IV
        hist_reg[i] <= link.start_iv ^ scoc_pkg::scoc_ones(i + 1);
      end else if (state_reg == ST_RUN && in_fire) begin
        hist_reg[i] <= (i == 0) ?
          scoc_pkg::scoc_shift(hist_reg[0], ct_fb, scoc_pkg::BLK_W) :
          hist_reg[(i == 0) ? 0 : i - 1];
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (state_reg == ST_RUN && in_fire && is_dec_auth
        && nblk_reg < NB_W'(MAX_BLKS)) begin
      mem[nblk_reg[NB_W-2:0]] <= p_dec;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      out_valid_reg <= 1'b0;
      out_data_reg  <= scoc_pkg::BLK_ZERO;
      out_last_reg  <= 1'b0;
    end else if (emit) begin
      out_valid_reg <= 1'b1;
      out_data_reg  <= out_next;
      out_last_reg  <= (state_reg == ST_RUN && !is_auth && link.in_last)
                    || (state_reg == ST_EMIT
                        && cnt_reg == scoc_pkg::CNT_ONE)
                    || (state_reg == ST_REL && rd_reg == rel_last);
    end else if (link.out_ready) begin
      out_valid_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      state_reg <= ST_IDLE;
      dir_reg   <= 1'b0;
      omode_reg <= scoc_pkg::SCOC_OUT_XOR;
      gmode_reg <= scoc_pkg::SCOC_GEN_SYNC;
      key_reg   <= scoc_pkg::BLK_ZERO;
      red_reg   <= scoc_pkg::BLK_ZERO;
      zt_reg    <= scoc_pkg::BLK_ZERO;
      zinv_reg  <= scoc_pkg::BLK_ONE;
      sq_reg    <= scoc_pkg::BLK_ZERO;
      wprev_reg <= scoc_pkg::BLK_ZERO;
      za_reg    <= scoc_pkg::BLK_ZERO;
      zb_reg    <= scoc_pkg::BLK_ZERO;
      pm1_reg   <= scoc_pkg::BLK_ZERO;
      pm2_reg   <= scoc_pkg::BLK_ZERO;
      cnt_reg   <= scoc_pkg::CNT_ZERO;
      nblk_reg  <= '0;
      rd_reg    <= '0;
      ovf_reg   <= 1'b0;
      done_reg  <= 1'b0;
      accept_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      unique case (state_reg)
        ST_IDLE: begin
          if (start_fire) begin
            dir_reg   <= link.start_dir;
            omode_reg <= link.start_out_mode;
            gmode_reg <= link.start_gen_mode;
            key_reg   <= link.start_key;
            red_reg   <= link.start_red;
            wprev_reg <= scoc_pkg::BLK_ZERO;
            nblk_reg  <= '0;
            ovf_reg   <= 1'b0;
            state_reg <= (link.start_out_mode == scoc_pkg::SCOC_OUT_AUTH)
                       ? ST_FIND : ST_RUN;
          end
        end
        ST_FIND: begin
          if (z_cur != scoc_pkg::BLK_ZERO) begin
            zt_reg    <= z_cur;
            sq_reg    <= z_cur;
            zinv_reg  <= scoc_pkg::BLK_ONE;
            cnt_reg   <= scoc_pkg::CNT_ZERO;
            state_reg <= dir_reg ? ST_INV : ST_RUN;
          end
        end
        ST_INV: begin
          // a^(2^n-2) by repeated squaring, one step a cycle
          sq_reg   <= sq_next;
          zinv_reg <= scoc_pkg::scoc_gf_mul(zinv_reg, sq_next);
          cnt_reg  <= cnt_reg + scoc_pkg::CNT_ONE;
          if (cnt_reg == scoc_pkg::INV_ITERS - scoc_pkg::CNT_ONE) begin
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (in_fire) begin
            if (is_dec_auth) begin
              wprev_reg <= w_dec;
              pm2_reg   <= pm1_reg;
              pm1_reg   <= p_dec;
              if (nblk_reg < NB_W'(MAX_BLKS)) nblk_reg <= nblk_reg + NB_W'(1);
              else ovf_reg <= 1'b1;
            end else if (is_auth) begin
              wprev_reg <= w_enc;
            end
            if (link.in_last) begin
              cnt_reg <= scoc_pkg::CNT_ZERO;
              if (!is_auth) begin
                done_reg   <= 1'b1;
                accept_reg <= 1'b1;
                state_reg  <= ST_IDLE;
              end else begin
                state_reg <= dir_reg ? ST_VERD : ST_TAIL;
              end
            end
          end
        end
        ST_TAIL: begin
          cnt_reg <= cnt_reg + scoc_pkg::CNT_ONE;
          if (cnt_reg == scoc_pkg::CNT_ZERO) begin
            za_reg <= z_cur;
          end else begin
            zb_reg    <= z_cur;
            cnt_reg   <= scoc_pkg::CNT_ZERO;
            state_reg <= ST_EMIT;
          end
        end
        ST_EMIT: begin
          if (out_free) begin
            wprev_reg <= tail_w;
            cnt_reg   <= cnt_reg + scoc_pkg::CNT_ONE;
            if (cnt_reg == scoc_pkg::CNT_ONE) begin
              done_reg   <= 1'b1;
              accept_reg <= 1'b1;
              state_reg  <= ST_IDLE;
            end
          end
        end
        ST_VERD: begin
          done_reg   <= 1'b1;
          accept_reg <= verdict_ok;
          rd_reg     <= '0;
          state_reg  <= (verdict_ok && nblk_reg > NB_W'(2))
                      ? ST_REL : ST_IDLE;
        end
        ST_REL: begin
          if (out_free) begin
            rd_reg <= rd_reg + NB_W'(1);
            if (rd_reg == rel_last) state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end
endmodule : scoc_combiner

//--- common/scoc_pkg.sv
// Purpose: Shared constants, types and bit helpers for the stream combiner.
// Assumes: Block width is fixed here; both ends import nothing.
// Notes:   Field multiply is a bit-serial loop, one block per call.
package scoc_pkg;

  localparam int BLK_W  = 64;
  localparam int BYTE_W = 8;
  localparam int KEEP_W = BLK_W / BYTE_W;
  localparam int CNT_W  = $clog2(BLK_W) + 1;

  typedef logic [BLK_W-1:0] scoc_blk_t;

  // Low terms of x^64 + x^4 + x^3 + x + 1
  localparam scoc_blk_t POLY_LOW  = 64'h0000_0000_0000_001B;
  localparam scoc_blk_t BLK_ZERO  = 64'h0000_0000_0000_0000;
  localparam scoc_blk_t BLK_ONE   = 64'h0000_0000_0000_0001;
  localparam logic [CNT_W-1:0] INV_ITERS = CNT_W'(BLK_W - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO  = 7'h00;
  localparam logic [CNT_W-1:0] CNT_ONE   = 7'h01;
  // Bits of generator state refreshed per step
  localparam int GEN_FEED = 8;

  typedef enum logic {
    SCOC_OUT_XOR  = 1'b0,
    SCOC_OUT_AUTH = 1'b1
  } scoc_out_e;

  typedef enum logic {
    SCOC_GEN_SYNC  = 1'b0,
    SCOC_GEN_SSYNC = 1'b1
  } scoc_gen_e;

  // j leftmost bits of a, right aligned; valid for 1 <= j <= BLK_W
  function automatic scoc_blk_t scoc_trunc(input scoc_blk_t a,
                                           input int j);
    scoc_blk_t r;
    r = a >> (BLK_W - j);
    return r;
  endfunction : scoc_trunc

  // k ones, right aligned
  function automatic scoc_blk_t scoc_ones(input int k);
    scoc_blk_t r;
    r = (k >= BLK_W) ? ~BLK_ZERO : ((BLK_ONE << k) - BLK_ONE);
    return r;
  endfunction : scoc_ones

  // Shift x left by k, low k bits from v
  function automatic scoc_blk_t scoc_shift(input scoc_blk_t x,
                                           input scoc_blk_t v,
                                           input int k);
    scoc_blk_t r;
    if (k >= BLK_W) r = v;
    else r = (x << k) | (v & scoc_ones(k));
    return r;
  endfunction : scoc_shift

  // Multiply in GF(2^64), MSB is the x^63 coefficient
  function automatic scoc_blk_t scoc_gf_mul(input scoc_blk_t a,
                                            input scoc_blk_t b);
    scoc_blk_t acc;
    scoc_blk_t sh;
    acc = BLK_ZERO;
    sh  = a;
    for (int i = 0; i < BLK_W; i++) begin
      if (b[i]) acc = acc ^ sh;
      sh = sh[BLK_W-1] ? ((sh << 1) ^ POLY_LOW) : (sh << 1);
    end
    return acc;
  endfunction : scoc_gf_mul

endpackage : scoc_pkg

//--- common/scoc_link_if.sv
// Purpose: Link between host end and combiner end.
// Assumes: Both ends run on one clock; valid/ready transfers.
// Notes:   No clocking block; testbench joins the ends here.
`timescale 1ns/1ps
interface scoc_link_if;
  logic                start_valid;
  logic                start_ready;
  logic                start_dir;
  scoc_pkg::scoc_out_e start_out_mode;
  scoc_pkg::scoc_gen_e start_gen_mode;
  scoc_pkg::scoc_blk_t start_key;
  scoc_pkg::scoc_blk_t start_iv;
  scoc_pkg::scoc_blk_t start_red;
  logic                in_valid;
  logic                in_ready;
  scoc_pkg::scoc_blk_t in_data;
  logic                in_last;
  logic                out_valid;
  logic                out_ready;
  scoc_pkg::scoc_blk_t out_data;
  logic                out_last;
  logic                done;
  logic                accept;

  modport dev (
    input  start_valid, start_dir, start_out_mode, start_gen_mode,
    input  start_key, start_iv, start_red,
    output start_ready,
    input  in_valid, in_data, in_last,
    output in_ready,
    output out_valid, out_data, out_last, done, accept,
    input  out_ready
  );

  modport host (
    output start_valid, start_dir, start_out_mode, start_gen_mode,
    output start_key, start_iv, start_red,
    input  start_ready,
    output in_valid, in_data, in_last,
    input  in_ready,
    input  out_valid, out_data, out_last, done, accept,
    output out_ready
  );
endinterface : scoc_link_if

//--- rtl/scoc_host_end.sv
// Purpose: Host end: frames user messages onto the link.
// Assumes: User gives whole blocks; last block may be partly kept.
// Notes:   Dropped bytes are zero filled so length stays whole blocks.
`timescale 1ns/1ps
module scoc_host_end (
  input  wire logic                        sys_clk_i,
  input  wire logic                        srst_i,
  scoc_link_if.host                        link,
  input  wire logic                        usr_start_i,
  input  wire logic                        usr_dir_i,
  input  wire logic                        usr_auth_i,
  input  wire logic                        usr_ssync_i,
  input  wire scoc_pkg::scoc_blk_t         usr_key_i,
  input  wire scoc_pkg::scoc_blk_t         usr_iv_i,
  input  wire scoc_pkg::scoc_blk_t         usr_red_i,
  output logic                             usr_start_ready_o,
  input  wire logic                        usr_valid_i,
  input  wire scoc_pkg::scoc_blk_t         usr_data_i,
  input  wire logic [scoc_pkg::KEEP_W-1:0] usr_keep_i,
  input  wire logic                        usr_last_i,
  output logic                             usr_ready_o,
  output logic                             usr_out_valid_o,
  output scoc_pkg::scoc_blk_t              usr_out_data_o,
  output logic                             usr_out_last_o,
  input  wire logic                        usr_out_ready_i,
  output logic                             usr_done_o,
  output logic                             usr_accept_o
);
  logic                st_valid_reg;
  logic                st_dir_reg;
  scoc_pkg::scoc_out_e st_out_reg;
  scoc_pkg::scoc_gen_e st_gen_reg;
  scoc_pkg::scoc_blk_t st_key_reg;
  scoc_pkg::scoc_blk_t st_iv_reg;
  scoc_pkg::scoc_blk_t st_red_reg;
  logic                in_valid_reg;
  scoc_pkg::scoc_blk_t in_data_reg;
  logic                in_last_reg;
  logic                o_valid_reg;
  scoc_pkg::scoc_blk_t o_data_reg;
  logic                o_last_reg;
  logic                done_reg;
  logic                accept_reg;
  scoc_pkg::scoc_blk_t keep_mask;
  logic                usr_take;
  logic                link_take;

  always_comb begin
    for (int b = 0; b < scoc_pkg::KEEP_W; b++) begin
      keep_mask[b*scoc_pkg::BYTE_W +: scoc_pkg::BYTE_W] =
        {scoc_pkg::BYTE_W{usr_keep_i[b]}};
    end
  end

  assign usr_start_ready_o = !st_valid_reg;
  assign usr_ready_o       = !in_valid_reg || link.in_ready;
  assign usr_take          = usr_valid_i && usr_ready_o;
  assign link_take         = !o_valid_reg || usr_out_ready_i;

  assign link.start_valid    = st_valid_reg;
  assign link.start_dir      = st_dir_reg;
  assign link.start_out_mode = st_out_reg;
  assign link.start_gen_mode = st_gen_reg;
  assign link.start_key      = st_key_reg;
  assign link.start_iv       = st_iv_reg;
  // Agreed redundancy value goes to both directions alike
  assign link.start_red      = st_red_reg;
  assign link.in_valid       = in_valid_reg;
  assign link.in_data        = in_data_reg;
  assign link.in_last        = in_last_reg;
  assign link.out_ready      = link_take;

  assign usr_out_valid_o = o_valid_reg;
  assign usr_out_data_o  = o_data_reg;
  assign usr_out_last_o  = o_last_reg;
  assign usr_done_o      = done_reg;
  assign usr_accept_o    = accept_reg;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      st_valid_reg <= 1'b0;
    end else if (usr_start_i && !st_valid_reg) begin
      st_valid_reg <= 1'b1;
    end else if (link.start_ready) begin
      st_valid_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      st_dir_reg <= 1'b0;
      st_out_reg <= scoc_pkg::SCOC_OUT_XOR;
      st_gen_reg <= scoc_pkg::SCOC_GEN_SYNC;
      st_key_reg <= scoc_pkg::BLK_ZERO;
      st_iv_reg  <= scoc_pkg::BLK_ZERO;
      st_red_reg <= scoc_pkg::BLK_ZERO;
    end else if (usr_start_i && !st_valid_reg) begin
      // Caller must not repeat a key and IV pair
      st_dir_reg <= usr_dir_i;
      st_out_reg <= scoc_pkg::scoc_out_e'(usr_auth_i);
      st_gen_reg <= scoc_pkg::scoc_gen_e'(usr_ssync_i);
      st_key_reg <= usr_key_i;
      st_iv_reg  <= usr_iv_i;
      st_red_reg <= usr_red_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      in_valid_reg <= 1'b0;
      in_data_reg  <= scoc_pkg::BLK_ZERO;
      in_last_reg  <= 1'b0;
    end else if (usr_ready_o) begin
      in_valid_reg <= usr_valid_i;
      if (usr_take) begin
        in_data_reg <= usr_data_i & keep_mask;
        in_last_reg <= usr_last_i;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      o_valid_reg <= 1'b0;
      o_data_reg  <= scoc_pkg::BLK_ZERO;
      o_last_reg  <= 1'b0;
      done_reg    <= 1'b0;
      accept_reg  <= 1'b0;
    end else begin
      done_reg <= link.done;
      if (link.done) accept_reg <= link.accept;
      if (link_take) begin
        o_valid_reg <= link.out_valid;
        if (link.out_valid) begin
          o_data_reg <= link.out_data;
          o_last_reg <= link.out_last;
        end
      end
    end
  end
endmodule : scoc_host_end

//--- tb/scoc_link_monitor.sv
// Purpose: Link assertions between host end and combiner.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Sees the wire only; user side is judged by the bench.
`timescale 1ns/1ps
module scoc_link_monitor (
  input wire logic                sys_clk_i,
  input wire logic                srst_i,
  input wire logic                start_valid,
  input wire logic                start_ready,
  input wire logic                in_valid,
  input wire logic                in_ready,
  input wire scoc_pkg::scoc_blk_t in_data,
  input wire logic                in_last,
  input wire logic                out_valid,
  input wire logic                out_ready,
  input wire scoc_pkg::scoc_blk_t out_data,
  input wire logic                done,
  input wire logic                accept
);
  logic last_seen_reg;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  // Cleared by done so a verdict never borrows an older last block
  always_ff @(posedge sys_clk_i) begin
    if (srst_i || done) last_seen_reg <= 1'h0;
    else if (in_valid && in_ready && in_last) last_seen_reg <= 1'h1;
  end
  sequence s_start_fire; start_valid && start_ready; endsequence
  sequence s_quiet2; !out_valid ##1 !out_valid; endsequence
  property p_start_busy; s_start_fire |=> !start_ready; endproperty
  property p_start_hold; start_valid && !start_ready |=> start_valid;
  endproperty
  property p_in_hold;
    in_valid && !in_ready |=> in_valid && $stable(in_data);
  endproperty
  property p_out_hold;
    out_valid && !out_ready |=> out_valid && $stable(out_data);
  endproperty
  property p_done_pulse; done |=> !done; endproperty
  property p_done_after_last; done |-> last_seen_reg; endproperty
  property p_reject_silent; done && !accept |-> s_quiet2; endproperty
  property p_data_when_busy; in_valid && in_ready |-> !start_ready;
  endproperty
  a_start_busy: assert property (p_start_busy)
    else $error("start_ready high after start");
  a_start_hold: assert property (p_start_hold)
    else $error("start request dropped");
  a_in_hold: assert property (p_in_hold)
    else $error("input block changed while waiting");
  a_out_hold: assert property (p_out_hold)
    else $error("output block changed while waiting");
  a_done_pulse: assert property (p_done_pulse)
    else $error("done longer than one cycle");
  a_done_after_last: assert property (p_done_after_last)
    else $error("verdict before last block");
  a_reject_silent: assert property (p_reject_silent)
    else $error("output after reject");
  a_data_when_busy: assert property (p_data_when_busy)
    else $error("data taken while idle");
endmodule : scoc_link_monitor

//--- tb/scoc_tb_top.sv
// Purpose: Self-checking bench, host end and combiner joined by link.
// Assumes: Output side stalls on alternate cycles once stall is set.
// Notes:   Only Z0 is modelled; later blocks judged by round trip.
`timescale 1ns/1ps
module scoc_tb_top;
  localparam scoc_pkg::scoc_blk_t KEY = 64'h0F1E_2D3C_4B5A_6978;
  localparam scoc_pkg::scoc_blk_t IV  = 64'h1357_9BDF_2468_ACE0;
  logic sys_clk_i, srst_i, usr_start_i, usr_dir_i, usr_auth_i, usr_ssync_i;
  logic usr_start_ready_o, usr_valid_i, usr_last_i, usr_ready_o;
  logic usr_out_valid_o, usr_out_last_o, usr_done_o, usr_accept_o, acc;
  logic ordy, stall;
  logic [scoc_pkg::KEEP_W-1:0] keep;
  scoc_pkg::scoc_blk_t iv;
  scoc_pkg::scoc_blk_t usr_data_i, usr_out_data_o, blk[4], pt[4];
  scoc_pkg::scoc_blk_t outq[$], lq[$];
  int n_errors = 0, checked = 0, done_n;
  scoc_link_if link ();
  scoc_host_end scoc_host_end_i (.sys_clk_i, .srst_i, .link(link),
    .usr_start_i, .usr_dir_i, .usr_auth_i, .usr_ssync_i, .usr_key_i(KEY),
    .usr_iv_i(iv), .usr_red_i(64'h0000_0000_0000_0000),
    .usr_start_ready_o, .usr_valid_i, .usr_data_i, .usr_keep_i(keep),
    .usr_last_i, .usr_ready_o, .usr_out_valid_o, .usr_out_data_o,
    .usr_out_last_o, .usr_out_ready_i(ordy), .usr_done_o, .usr_accept_o);
  scoc_combiner #(.MAX_BLKS(8), .R_FB(2)) scoc_combiner_i (.sys_clk_i,
    .srst_i, .link(link));
  scoc_link_monitor scoc_link_monitor_i (.sys_clk_i, .srst_i,
    .start_valid(link.start_valid), .start_ready(link.start_ready),
    .in_valid(link.in_valid), .in_ready(link.in_ready),
    .in_data(link.in_data), .in_last(link.in_last),
    .out_valid(link.out_valid), .out_ready(link.out_ready),
    .out_data(link.out_data), .done(link.done), .accept(link.accept));
  initial begin
    sys_clk_i = 1'h0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    if (usr_out_valid_o && ordy) outq.push_back(usr_out_data_o);
    // Alternate-cycle stall exercises the hold and refusal paths
    ordy <= !stall || !ordy;
    if (link.out_valid && link.out_ready) lq.push_back(link.out_data);
    if (usr_done_o) begin
      done_n++;
      acc = usr_accept_o;
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report();
    if (n_errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  // One whole message through the user side, then count what came back
  task automatic go(input logic dir, auth, ss, input int n, input int ne);
    int k;
    outq.delete();
    lq.delete();
    done_n = 0;
    usr_start_i <= 1'h1;
    usr_dir_i   <= dir;
    usr_auth_i  <= auth;
    usr_ssync_i <= ss;
    @(posedge sys_clk_i);
    while (usr_start_ready_o !== 1'h1) @(posedge sys_clk_i);
    usr_start_i <= 1'h0;
    for (k = 0; k < n; k++) begin
      usr_valid_i <= 1'h1;
      usr_data_i  <= blk[k];
      usr_last_i  <= (k == n - 1);
      @(posedge sys_clk_i);
      while (usr_ready_o !== 1'h1) @(posedge sys_clk_i);
    end
    usr_valid_i <= 1'h0;
    usr_last_i  <= 1'h0;
    for (k = 0; k < 400 && done_n == 0; k++) @(posedge sys_clk_i);
    for (k = 0; k < 40 && outq.size() < ne; k++) @(posedge sys_clk_i);
    repeat (4) @(posedge sys_clk_i);
    chk(64'(done_n), 64'h1);
    chk(64'(outq.size()), 64'(ne));
  endtask : go
  // Encrypt two blocks, decrypt the result, expect the plaintext back
  task automatic rt(input logic auth, input logic ss, input int ne);
    blk = pt;
    go(1'h0, auth, ss, 2, ne);
    if (!auth && !ss) chk(lq[0], pt[0] ^ iv);
    chk(64'(acc), 64'h1);
    for (int i = 0; i < ne; i++) blk[i] = outq[i];
    go(1'h1, auth, ss, ne, 2);
    chk(64'(acc), 64'h1);
    chk(outq[0], pt[0]);
    chk(outq[1], pt[1]);
  endtask : rt
  // Either the check block or the redundancy alone must reject
  task automatic tamper();
    for (int m = 2; m < 4; m++) begin
      blk[m] = blk[m] ^ 64'h0000_0000_0000_0001;
      go(1'h1, 1'h1, 1'h0, 4, 0);
      chk(64'(acc), 64'h0);
      blk[m] = blk[m] ^ 64'h0000_0000_0000_0001;
    end
  endtask : tamper
  // Unkept bytes go out as zero padding
  task automatic pad();
    blk = pt;
    keep <= 8'h0F;
    go(1'h0, 1'h0, 1'h0, 1, 1);
    chk(lq[0], (pt[0] & 64'h0000_0000_FFFF_FFFF) ^ iv);
    keep <= 8'hFF;
  endtask : pad
  // Zero IV makes the first keystream block zero, so it must be skipped
  task automatic skipz();
    iv <= 64'h0000_0000_0000_0000;
    rt(1'h1, 1'h0, 4);
    iv <= IV;
  endtask : skipz
  initial begin
    srst_i = 1'h1;
    {usr_start_i, usr_dir_i, usr_auth_i, usr_ssync_i} = 4'h0;
    {usr_valid_i, usr_last_i} = 2'h0;
    ordy = 1'h1;
    stall = 1'h0;
    iv = IV;
    keep = 8'hFF;
    usr_data_i = 64'h0000_0000_0000_0000;
    pt[0] = 64'h0123_4567_89AB_CDEF;
    pt[1] = 64'hFEDC_BA98_7654_3210;
    pt[2] = 64'h0000_0000_0000_0000;
    pt[3] = 64'h0000_0000_0000_0000;
    repeat (2) @(posedge sys_clk_i);
    srst_i <= 1'h0;
    rt(1'h0, 1'h0, 2);
    stall <= 1'h1;
    rt(1'h0, 1'h1, 2);
    rt(1'h1, 1'h0, 4);
    tamper();
    pad();
    skipz();
    final_report();
  end
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    n_errors++;
    final_report();
  end
endmodule : scoc_tb_top
